// File: logic/scs_pkg.sv
// Constants, codes and carrier types for the system clock select block
package scs_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 200;

  // Register map
  localparam logic [7:0] DIV_OFS  = 8'h95;
  localparam logic [7:0] CFG_OFS  = 8'h96;
  localparam logic [7:0] STAT_OFS = 8'h97;

  // Reset values
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'hff;
  localparam logic [7:0] ZERO_RD  = 8'h00;

  // Configuration byte fields
  localparam int SRC_LO_POS  = 0;
  localparam int SRC_HI_POS  = 1;
  localparam int RSVD_POS    = 2;
  localparam int RC_FULL_POS = 3;
  localparam int FILT_POS    = 4;

  // Status register fields
  localparam int ST_SRC_OK_POS  = 0;
  localparam int ST_ACTIVE_POS  = 1;
  localparam int ST_FILT_POS    = 2;
  localparam int ST_RC_HALF_POS = 3;
  localparam int ST_SRC_LO_POS  = 4;
  localparam int ST_SRC_HI_POS  = 5;
  localparam int ST_PEND_POS    = 6;
  localparam int ST_RUN_POS     = 7;

  // Filter settle time: least time, rounded up
  localparam int FILT_NS  = 20;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;

  // Oscillator loss timeout: longest time, rounded down
  localparam int OSC_TIMEOUT_NS  = 1000;
  localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS * CLK_MHZ) / 1000;

  // Oscillator source codes
  typedef enum logic [1:0] {
    SRC_EXT  = 2'b00,
    SRC_XTAL = 2'b01,
    SRC_RSVD = 2'b10,
    SRC_RC   = 2'b11
  } scs_src_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scs_bus_req_t;

  // Decoded clock configuration
  typedef struct packed {
    logic     filt_en;
    logic     rc_full;
    scs_src_t src;
  } scs_clk_cfg_t;

endpackage

// File: logic/scs_in_filter.sv
// Glitch filter for the crystal input clock path
`timescale 1ns/100ps
module scs_in_filter
#(
  parameter int STABLE_CYC = scs_pkg::FILT_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic en,
  input  wire logic raw,
  output logic      filt
);

  import scs_pkg::*;

  localparam int CW = $clog2(STABLE_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic          out_q;

  // With en high, level moves only after STABLE_CYC samples that disagree with it; with en low it follows raw
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!en)
      begin
        cnt_q <= '0;
        out_q <= raw;
      end
      else if (raw == out_q)
        cnt_q <= '0;
      else if (cnt_q == CW'(STABLE_CYC - 1))
      begin
        cnt_q <= '0;
        out_q <= raw;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign filt = out_q;

endmodule

// File: logic/scs_clk_div.sv
// Programmable divider from oscillator clock to system clock
`timescale 1ns/100ps
module scs_clk_div
#(
  parameter int DW = 8
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          run,
  input  wire logic          osc_lvl,
  input  wire logic          osc_rise,
  input  wire logic [DW-1:0] div_val,
  output logic               wrap,
  output logic               out_clk
);

  logic [DW-1:0] cnt_q;
  logic          half_q;

  // Zero passes through; N toggles every N+1 rises, period 2(N+1)
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      half_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt_q  <= '0;
        half_q <= 1'b0;
      end
      else if (div_val == '0)
      begin
        cnt_q  <= '0;
        half_q <= osc_lvl;
      end
      else if (osc_rise)
      begin
        if (cnt_q >= div_val)
        begin
          cnt_q  <= '0;
          half_q <= ~half_q;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // End of a whole output period, safe point to change the divisor
  assign wrap = osc_rise &
                ((div_val == '0) | ((cnt_q >= div_val) & half_q));
  assign out_clk = half_q;

endmodule

// File: logic/scs_clock_select.sv
// System clock source select, RC halving, input filter and divider
`timescale 1ns/100ps

module scs_clock_select
#(
  parameter int DIV_W      = 8,
  parameter int FILT_STAB  = scs_pkg::FILT_CYC,
  parameter int OSC_TO_CYC = scs_pkg::OSC_TIMEOUT_CYC
)
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [7:0]            cfg_nv,
  input  wire logic                  rc_osc,
  input  wire logic                  crystal_input_pin,
  input  wire scs_pkg::scs_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  output logic                       crystal_output_pin,
  output logic                       crystal_output_oe,
  output logic                       rc_osc_enable,
  output logic                       osc_clk,
  output logic                       sys_clk,
  output logic                       sys_clk_rise,
  output logic                       osc_active
);

  import scs_pkg::*;

  // Idle counter saturates, so a long stall never wraps back to active
  localparam int TW = $clog2(OSC_TO_CYC + 1);

  typedef enum {
    ST_LOAD,
    ST_RUN
  } scs_state_t;

  scs_state_t   state_q;
  logic [7:0]   cfg_q;
  scs_clk_cfg_t ccfg;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_act_q;
  logic         div_pend_q;
  logic         rc_q;
  logic         rc_half_q;
  logic         xin_filt;
  logic         osc_sel_d;
  logic         osc_q;
  logic         osc_rise;
  logic         run;
  logic         div_wrap;
  logic         div_clk;
  logic [TW-1:0] idle_cnt_q;
  logic [7:0]   stat;
  logic         wr_div;
  logic         rc_sel;
  logic         xtal_sel;

  // Configuration byte starts unprogrammed, then loads after reset
  // A later change on cfg_nv needs a fresh reset to take effect
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_LOAD;
      cfg_q   <= CFG_RST;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_LOAD:
        begin
          cfg_q   <= cfg_nv;
          state_q <= ST_RUN;
        end
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_LOAD;
      endcase
    end
  end

  assign run = (state_q == ST_RUN);

  // Bit 2 is never decoded, so it cannot affect selection
  always_comb
  begin
    ccfg.src     = scs_src_t'({cfg_q[SRC_HI_POS], cfg_q[SRC_LO_POS]});
    ccfg.rc_full = cfg_q[RC_FULL_POS];
    ccfg.filt_en = cfg_q[FILT_POS];
  end

  // RC sample and divide-by-two path
  // RC must stay below half of core_clk or its edges are missed
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rc_q      <= 1'b0;
      rc_half_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rc_q <= rc_osc;
      if (rc_osc && !rc_q)
        rc_half_q <= ~rc_half_q;
    end
  end

  // Filter sits only on the crystal input path
  scs_in_filter #(
    .STABLE_CYC (FILT_STAB)
  ) u_filt (
    .clk  (core_clk),
    .rst  (sys_rst),
    .ce   (clk_en),
    .en   (ccfg.filt_en),
    .raw  (crystal_input_pin),
    .filt (xin_filt)
  );

  // Source selection; reserved code gives no clock at all
  always_comb
  begin
    osc_sel_d = 1'b0;
    case (ccfg.src)
      SRC_RC:
        osc_sel_d = ccfg.rc_full ? rc_q : rc_half_q;
      SRC_XTAL:
        osc_sel_d = xin_filt;
      SRC_EXT:
        osc_sel_d = xin_filt;
      SRC_RSVD:
        osc_sel_d = 1'b0;
      default:
        osc_sel_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_q <= 1'b0;
    else if (clk_en)
      osc_q <= run & osc_sel_d;
  end

  assign osc_rise = run & osc_sel_d & ~osc_q;
  assign osc_clk  = osc_q;

  // One decode feeds both enables, so they can never overlap
  assign rc_sel   = run & (ccfg.src == SRC_RC);
  assign xtal_sel = run & (ccfg.src == SRC_XTAL);

  // Oscillator drivers follow the selected source
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rc_osc_enable      <= 1'b0;
      crystal_output_oe  <= 1'b0;
      crystal_output_pin <= 1'b0;
    end
    else if (clk_en)
    begin
      rc_osc_enable      <= rc_sel;
      // External clock mode leaves the output pin undriven
      crystal_output_oe  <= xtal_sel;
      crystal_output_pin <= xtal_sel & ~crystal_input_pin;
    end
  end

  // Loss detector: no selected edge within the timeout means idle
  // Only presence of edges is judged, never their rate
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idle_cnt_q <= TW'(OSC_TO_CYC);
      osc_active <= 1'b0;
    end
    else if (clk_en)
    begin
      if (osc_rise)
        idle_cnt_q <= '0;
      else if (idle_cnt_q != TW'(OSC_TO_CYC))
        idle_cnt_q <= idle_cnt_q + 1'b1;
      osc_active <= osc_rise | (idle_cnt_q < TW'(OSC_TO_CYC - 1));
    end
  end

  // Divider register and software access
  // Reads see a new value at once, even before the divider uses it
  assign wr_div = bus_req.wr & (bus_req.addr == DIV_OFS);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_q <= DIV_W'(DIV_RST);
    else if (clk_en && wr_div)
      div_q <= bus_req.wdata[DIV_W-1:0];
  end

  // New divisor waits for a period boundary so no runt pulse appears
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_act_q  <= DIV_W'(DIV_RST);
      div_pend_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run || !osc_active || div_wrap)
      begin
        div_act_q  <= wr_div ? bus_req.wdata[DIV_W-1:0] : div_q;
        div_pend_q <= 1'b0;
      end
      else if (wr_div)
        div_pend_q <= 1'b1;
    end
  end

  scs_clk_div #(
    .DW (DIV_W)
  ) u_div (
    .clk      (core_clk),
    .rst      (sys_rst),
    .ce       (clk_en),
    .run      (run),
    .osc_lvl  (osc_q),
    .osc_rise (osc_rise),
    .div_val  (div_act_q),
    .wrap     (div_wrap),
    .out_clk  (div_clk)
  );

  // System clock regenerated as a registered level and rise pulse
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sys_clk      <= 1'b0;
      sys_clk_rise <= 1'b0;
    end
    else if (clk_en)
    begin
      sys_clk      <= div_clk;
      sys_clk_rise <= div_clk & ~sys_clk;
    end
  end

  // Status view of the block's own state
  // Pending bit shows a divisor written but not yet in use
  always_comb
  begin
    stat                 = ZERO_RD;
    stat[ST_SRC_OK_POS]  = (ccfg.src != SRC_RSVD);
    stat[ST_ACTIVE_POS]  = osc_active;
    stat[ST_FILT_POS]    = ccfg.filt_en;
    stat[ST_RC_HALF_POS] = (ccfg.src == SRC_RC) & ~ccfg.rc_full;
    stat[ST_SRC_LO_POS]  = cfg_q[SRC_LO_POS];
    stat[ST_SRC_HI_POS]  = cfg_q[SRC_HI_POS];
    stat[ST_PEND_POS]    = div_pend_q;
    stat[ST_RUN_POS]     = run;
  end

  // Read data valid only in the cycle after the strobe
  // Clock enable low holds the read slot as well
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_rdata <= ZERO_RD;
    else if (clk_en)
    begin
      bus_rdata <= ZERO_RD;
      if (bus_req.rd)
      begin
        case (bus_req.addr)
          DIV_OFS:
            bus_rdata <= 8'(div_q);
          CFG_OFS:
            bus_rdata <= cfg_q;
          STAT_OFS:
            bus_rdata <= stat;
          default:
            bus_rdata <= ZERO_RD;
        endcase
      end
    end
  end

endmodule

// File: testbench/scs_clock_select_properties.sv
// Port checks for the clock select block
`timescale 1ns/100ps
module scs_chk
(
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire logic [7:0]            cfg_nv,
  input wire logic                  crystal_input_pin,
  input wire scs_pkg::scs_bus_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire logic                  crystal_output_pin,
  input wire logic                  crystal_output_oe,
  input wire logic                  rc_osc_enable,
  input wire logic                  osc_clk,
  input wire logic                  sys_clk,
  input wire logic                  sys_clk_rise
);
  import scs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle: assert property (
    clk_en && !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside its slot");
  a_div_readback: assert property (
    clk_en && bus_req.wr && bus_req.addr == DIV_OFS ##1
    clk_en && bus_req.rd && bus_req.addr == DIV_OFS
    |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("divider readback wrong");
  a_xout_invert: assert property (
    $past(crystal_output_oe) && crystal_output_oe
    |-> crystal_output_pin == !$past(crystal_input_pin))
    else $error("amplifier output not inverted");
  a_xout_quiet: assert property (
    !crystal_output_oe |-> !crystal_output_pin)
    else $error("output pin active while undriven");
  a_one_source: assert property (
    !(rc_osc_enable && crystal_output_oe))
    else $error("two sources enabled");
  a_rise_edge: assert property (
    sys_clk_rise |-> sys_clk && !$past(sys_clk))
    else $error("rise pulse without rise");
  a_rise_single: assert property (
    sys_clk_rise |=> !sys_clk_rise)
    else $error("rise pulse too long");
  a_reserved_quiet: assert property (
    cfg_nv[1:0] == 2'b10 && $stable(cfg_nv)
    |-> !osc_clk && !rc_osc_enable && !crystal_output_oe)
    else $error("clock in reserved mode");

  c_rise: cover property (sys_clk_rise);
  c_xtal: cover property (crystal_output_oe);
  c_read: cover property (bus_req.rd ##1 bus_rdata != 8'h00);
endmodule

bind scs_clock_select scs_chk u_chk (.core_clk, .sys_rst, .clk_en, .cfg_nv,
  .crystal_input_pin, .bus_req, .bus_rdata, .crystal_output_pin,
  .crystal_output_oe, .rc_osc_enable, .osc_clk, .sys_clk, .sys_clk_rise);

// File: testbench/testbench.sv
// Self-checking bench for the clock select block
`timescale 1ns/100ps
module testbench;
  import scs_pkg::*;
  typedef struct {
    logic [7:0] c;
    logic [7:0] n;
    int         h;
    int         r;
  } scs_row_t;

  logic         core_clk = 0;
  logic         sys_rst = 1;
  logic [7:0]   cfg_nv = 8'hff;
  logic         src = 0;
  logic         src_p = 0;
  logic         osc_p = 0;
  scs_bus_req_t bus_req = '0;
  logic [7:0]   bus_rdata;
  logic         crystal_output_oe;
  logic         rc_osc_enable;
  logic         osc_clk;
  logic         sys_clk_rise;
  logic         osc_active;
  int           hp = 2;
  int           tc = 0;
  int           n_src = 0;
  int           n_osc = 0;
  int           n_sys = 0;
  int           miscompares = 0;
  int           num_checks = 0;
  // Filter rows that expect a clock use a half period of 6, clear of the 4-sample limit
  scs_row_t     rows [10] = '{
    '{8'hff, 8'h00, 2, 1}, '{8'hff, 8'h01, 2, 1}, '{8'hff, 8'hff, 2, 1},
    '{8'hf7, 8'h02, 2, 2}, '{8'hfb, 8'h00, 2, 1}, '{8'hfd, 8'h00, 6, 1},
    '{8'hfd, 8'h00, 1, 0}, '{8'hed, 8'h00, 1, 1}, '{8'hfe, 8'h00, 2, 0},
    '{8'hfc, 8'h03, 6, 1}};

  scs_clock_select dut (.core_clk, .sys_rst, .clk_en(1'b1), .cfg_nv,
    .rc_osc(src), .crystal_input_pin(src), .bus_req, .bus_rdata,
    .crystal_output_pin(), .crystal_output_oe, .rc_osc_enable, .osc_clk,
    .sys_clk(), .sys_clk_rise, .osc_active);

  always #2.5 core_clk = ~core_clk;

  // One source wave feeds both oscillator inputs
  always @(posedge core_clk)
  begin
    tc <= (tc >= hp - 1) ? 0 : tc + 1;
    if (tc >= hp - 1)
      src <= ~src;
    src_p <= src;
    osc_p <= osc_clk;
    n_src <= n_src + int'(src & ~src_p);
    n_osc <= n_osc + int'(osc_clk & ~osc_p);
    n_sys <= n_sys + int'(sys_clk_rise);
  end

  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{w, r, a, d};
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    xfer(0, 1, a, 8'h00);
    @(posedge core_clk);
    bus_req <= '0;
    #1 v = bus_rdata;
  endtask

  task automatic do_reset(logic [7:0] c);
    @(posedge core_clk);
    sys_rst <= 1;
    cfg_nv <= c;
    repeat (16) @(posedge core_clk);
    sys_rst <= 0;
    repeat (4) @(posedge core_clk);
  endtask

  function automatic logic [7:0] near(int a, int b, int t);
    return {7'h0, (a - b <= t) && (b - a <= t)};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] v;
    logic [7:0] e;
    int         k;
    int         m;
    int         s0;
    int         o0;
    int         y0;
    foreach (rows[i])
    begin
      hp <= rows[i].h;
      do_reset(rows[i].c);
      rd(DIV_OFS, v);
      chk("div_reset", v, DIV_RST);
      rd(CFG_OFS, v);
      chk("cfg_byte", v, rows[i].c);
      chk("xtal_oe", {7'h0, crystal_output_oe},
          {7'h0, rows[i].c[1:0] == 2'b01});
      chk("rc_en", {7'h0, rc_osc_enable},
          {7'h0, rows[i].c[1:0] == 2'b11});
      xfer(1, 0, DIV_OFS, rows[i].n);
      xfer(0, 0, DIV_OFS, 8'h00);
      repeat (100) @(posedge core_clk);
      s0 = n_src;
      o0 = n_osc;
      y0 = n_sys;
      repeat (4096) @(posedge core_clk);
      s0 = n_src - s0;
      o0 = n_osc - o0;
      y0 = n_sys - y0;
      k = (rows[i].n == 0) ? 1 : 2 * (rows[i].n + 1);
      // A row with no clock allows at most one oscillator rise
      m = (rows[i].r == 0) ? 1 : rows[i].r;
      s0 = (rows[i].r == 0) ? 0 : s0;
      chk("osc_rate", near(o0 * m, s0, rows[i].r + 1),
          8'h01);
      chk("sys_rate", near(y0 * k, o0, k), 8'h01);
      chk("osc_act", {7'h0, osc_active}, {7'h0, rows[i].r != 0});
    end
    // Back-to-back write and read, then unmapped and read-only places
    xfer(1, 0, DIV_OFS, 8'h5a);
    rd(DIV_OFS, v);
    chk("div_rw", v, 8'h5a);
    xfer(1, 0, 8'h94, 8'h33);
    xfer(1, 0, CFG_OFS, 8'h00);
    rd(8'h94, v);
    chk("unmapped", v, 8'h00);
    rd(CFG_OFS, v);
    chk("cfg_ro", v, 8'hfc);
    rd(DIV_OFS, v);
    chk("div_keep", v, 8'h5a);
    // Old divisor period has ended by now, so nothing is pending
    repeat (200) @(posedge core_clk);
    e = '0;
    e[ST_SRC_OK_POS] = 1'b1;
    e[ST_ACTIVE_POS] = 1'b1;
    e[ST_FILT_POS] = 1'b1;
    e[ST_RUN_POS] = 1'b1;
    rd(STAT_OFS, v);
    chk("status", v, e);
    tally_and_finish();
  end
endmodule
